// [tlic_pkg.sv]
package tlic_pkg;

  // ******************************************************
  // Register offsets on the plain register port
  // ******************************************************
  localparam logic [2:0] TLIC_OFS_CTRL = 3'h0;
  localparam logic [2:0] TLIC_OFS_CFLAG = 3'h1;
  localparam logic [2:0] TLIC_OFS_CPRI = 3'h2;
  localparam logic [2:0] TLIC_OFS_PFLAG = 3'h3;
  localparam logic [2:0] TLIC_OFS_PEN = 3'h4;
  localparam logic [2:0] TLIC_OFS_PPRI = 3'h5;
  localparam logic [2:0] TLIC_OFS_RSTCTL = 3'h6;
  localparam logic [2:0] TLIC_OFS_STATUS = 3'h7;

  // ******************************************************
  // Field positions and reset values
  // ******************************************************
  localparam int TLIC_GHE_BIT = 7;
  localparam int TLIC_PLE_BIT = 6;
  localparam int TLIC_PRIORITY_LEVELS_ENABLE_BIT = 7;
  localparam logic [7:0] TLIC_CTRL_MASK = 8'hdf;
  localparam logic [7:0] TLIC_RST_BYTE = 8'h00;
  localparam logic [4:1] TLIC_CPRI_RST = 4'hf;
  localparam logic [7:0] TLIC_PPRI_RST = 8'hff;
  // Core sources: 0 ext0, 1 ext1, 2 ext2, 3 port change, 4 timer0
  localparam int TLIC_NCORE = 5;
  localparam int TLIC_NSRC = 13;
  localparam logic [12:0] TLIC_PERIPH_MASK = 13'h1fe0;

  // ******************************************************
  // Vector addresses
  // ******************************************************
  localparam logic [15:0] TLIC_VEC_HIGH = 16'h0008;
  localparam logic [15:0] TLIC_VEC_LOW = 16'h0018;

  // ******************************************************
  // Service state and block state
  // ******************************************************
  typedef enum logic [3:0] {
    TLIC_SVC_NONE = 4'b0001,
    TLIC_SVC_LOW = 4'b0010,
    TLIC_SVC_HIGH = 4'b0100,
    TLIC_SVC_HOL = 4'b1000
  } tlic_svc_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [7:0] ctrl;
    logic [4:0] cflag;
    logic [4:1] cpri;
    logic [7:0] pflag;
    logic [7:0] pen;
    logic [7:0] ppri;
    logic priority_levels_enable;
    logic armed;
    tlic_svc_t svc;
    logic [7:0] rdata;
    logic vec_valid;
    logic [15:0] vec_addr;
    logic [15:0] push_addr;
  } tlic_state_t;

endpackage

// [tlic_ctrl.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

module tlic_ctrl
  import tlic_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Event sources
  input wire logic [2:0] ext_pin,
  input wire logic port_change_pin,
  input wire logic timer0_overflow,
  input wire logic [7:0] periph_event,
  // Core side
  input wire logic fetch_strobe,
  input wire logic return_from_interrupt,
  input wire logic [15:0] return_address,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  output logic push_valid,
  output logic [15:0] push_addr
);

  tlic_state_t st;
  tlic_state_t nx;
  logic [2:0] rise;
  logic chg;
  logic [4:0] ev;
  logic [12:0] all_f;
  logic [12:0] all_e;
  logic [12:0] all_p;
  logic req_h;
  logic req_l;
  logic take_h;
  logic take_l;
  logic in_high;

  // ******************************************************
  // Helpers
  // ******************************************************

  // Any source with flag, enable and selection all set
  function automatic logic tlic_any(input logic [12:0] f, input logic [12:0] e,
                                    input logic [12:0] sel);
    tlic_any = |(f & e & sel);
  endfunction

  // Register read decode
  function automatic logic [7:0] tlic_read(input tlic_state_t s, input logic [2:0] a);
    case (a)
      TLIC_OFS_CTRL: tlic_read = s.ctrl;
      TLIC_OFS_CFLAG: tlic_read = {3'h0, s.cflag};
      TLIC_OFS_CPRI: tlic_read = {3'h0, s.cpri, 1'b1};
      TLIC_OFS_PFLAG: tlic_read = s.pflag;
      TLIC_OFS_PEN: tlic_read = s.pen;
      TLIC_OFS_PPRI: tlic_read = s.ppri;
      TLIC_OFS_RSTCTL: tlic_read = {s.priority_levels_enable, 7'h00};
      TLIC_OFS_STATUS: tlic_read = {4'h0, s.svc};
      default: tlic_read = 8'h00;
    endcase
  endfunction

  // ******************************************************
  // Next state
  // ******************************************************

  // Synchronise, catch events, decode writes, select and take requests
  always_comb
  begin
    nx = st;
    nx.sync1 = {port_change_pin, ext_pin};
    nx.sync2 = st.sync1;
    nx.prev = st.sync2;
    rise = st.sync2[2:0] & ~st.prev[2:0];
    chg = st.sync2[3] ^ st.prev[3];
    ev = {timer0_overflow, chg, rise};

    // Register writes
    if (reg_write && reg_addr == TLIC_OFS_CTRL)
    begin
      nx.ctrl = reg_wdata & TLIC_CTRL_MASK;
    end
    if (reg_write && reg_addr == TLIC_OFS_CPRI)
    begin
      nx.cpri = reg_wdata[4:1];
    end
    if (reg_write && reg_addr == TLIC_OFS_PEN)
    begin
      nx.pen = reg_wdata;
    end
    if (reg_write && reg_addr == TLIC_OFS_PPRI)
    begin
      nx.ppri = reg_wdata;
    end
    if (reg_write && reg_addr == TLIC_OFS_RSTCTL)
    begin
      nx.priority_levels_enable = reg_wdata[TLIC_PRIORITY_LEVELS_ENABLE_BIT];
    end

    // Flags: event set wins over a software clear
    nx.cflag = ((reg_write && reg_addr == TLIC_OFS_CFLAG) ? reg_wdata[4:0] : st.cflag)
               | ev;
    nx.pflag = ((reg_write && reg_addr == TLIC_OFS_PFLAG) ? reg_wdata : st.pflag)
               | periph_event;

    // Per-level requests
    all_f = {st.pflag, st.cflag};
    all_e = {st.pen, st.ctrl[4:0]};
    all_p = {st.ppri, st.cpri, 1'b1};
    in_high = (st.svc == TLIC_SVC_HIGH) || (st.svc == TLIC_SVC_HOL);
    if (st.priority_levels_enable)
    begin
      req_h = st.ctrl[TLIC_GHE_BIT] && tlic_any(all_f, all_e, all_p);
      req_l = st.ctrl[TLIC_GHE_BIT] && st.ctrl[TLIC_PLE_BIT] && !in_high
              && tlic_any(all_f, all_e, ~all_p);
    end
    else
    begin
      // Priority bits ignored here
      req_h = st.ctrl[TLIC_GHE_BIT]
              && (tlic_any(all_f, all_e, ~TLIC_PERIPH_MASK)
              || (st.ctrl[TLIC_PLE_BIT] && tlic_any(all_f, all_e, TLIC_PERIPH_MASK)));
      req_l = 1'b0;
    end

    // Arm at one instruction cycle, take at the next
    nx.vec_valid = 1'b0;
    take_h = 1'b0;
    take_l = 1'b0;
    if (fetch_strobe)
    begin
      nx.armed = req_h || req_l;
      if (st.armed)
      begin
        take_h = req_h;
        take_l = req_l && !req_h;
      end
    end

    // Accept: vector, push, clear the level's enable
    if (take_h || take_l)
    begin
      nx.vec_valid = 1'b1;
      nx.vec_addr = take_h ? TLIC_VEC_HIGH : TLIC_VEC_LOW;
      nx.push_addr = return_address;
      nx.armed = 1'b0;
    end
    if (take_h)
    begin
      nx.ctrl[TLIC_GHE_BIT] = 1'b0;
    end
    if (take_l)
    begin
      nx.ctrl[TLIC_PLE_BIT] = 1'b0;
    end

    // Service level tracking and return handling
    case (st.svc)
      TLIC_SVC_NONE:
      begin
        if (take_h)
        begin
          nx.svc = TLIC_SVC_HIGH;
        end
        else if (take_l)
        begin
          nx.svc = TLIC_SVC_LOW;
        end
        else if (return_from_interrupt)
        begin
          nx.ctrl[TLIC_GHE_BIT] = 1'b1;
        end
      end
      TLIC_SVC_LOW:
      begin
        if (take_h)
        begin
          nx.svc = TLIC_SVC_HOL;
        end
        else if (return_from_interrupt)
        begin
          nx.svc = TLIC_SVC_NONE;
          if (st.priority_levels_enable)
          begin
            nx.ctrl[TLIC_PLE_BIT] = 1'b1;
          end
          else
          begin
            nx.ctrl[TLIC_GHE_BIT] = 1'b1;
          end
        end
      end
      TLIC_SVC_HIGH:
      begin
        if (return_from_interrupt)
        begin
          nx.svc = TLIC_SVC_NONE;
          nx.ctrl[TLIC_GHE_BIT] = 1'b1;
        end
      end
      TLIC_SVC_HOL:
      begin
        if (return_from_interrupt)
        begin
          nx.svc = TLIC_SVC_LOW;
          nx.ctrl[TLIC_GHE_BIT] = 1'b1;
        end
      end
      default:
      begin
        nx.svc = TLIC_SVC_NONE;
      end
    endcase

    // Read data one cycle after the strobe
    nx.rdata = reg_read ? tlic_read(st, reg_addr) : 8'h00;
  end

  // ******************************************************
  // State register
  // ******************************************************

  // Registers the whole state
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.sync1 <= 4'h0;
      st.sync2 <= 4'h0;
      st.prev <= 4'h0;
      st.ctrl <= TLIC_RST_BYTE;
      st.cflag <= 5'h00;
      st.cpri <= TLIC_CPRI_RST;
      st.pflag <= TLIC_RST_BYTE;
      st.pen <= TLIC_RST_BYTE;
      st.ppri <= TLIC_PPRI_RST;
      st.priority_levels_enable <= 1'b0;
      st.armed <= 1'b0;
      st.svc <= TLIC_SVC_NONE;
      st.rdata <= TLIC_RST_BYTE;
      st.vec_valid <= 1'b0;
      st.vec_addr <= 16'h0000;
      st.push_addr <= 16'h0000;
    end
    else
    begin
      st <= nx;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st.rdata;
  assign vector_valid = st.vec_valid;
  assign vector_addr = st.vec_addr;
  assign push_valid = st.vec_valid;
  assign push_addr = st.push_addr;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_accept;
    vector_valid ##0 push_valid;
  endsequence

  sequence s_low_accept;
    vector_valid && vector_addr == TLIC_VEC_LOW;
  endsequence

  vec_addr_legal_a: assert property (vector_valid |->
    (vector_addr == TLIC_VEC_HIGH || vector_addr == TLIC_VEC_LOW))
    else $error("vector address not a legal vector");

  compat_vec_a: assert property (vector_valid && !$past(st.priority_levels_enable) |->
    vector_addr == TLIC_VEC_HIGH)
    else $error("compatibility mode vectored away from high vector");

  push_ret_a: assert property (fetch_strobe && st.armed && (req_h || req_l) |=>
    s_accept ##0 push_addr == $past(return_address))
    else $error("accept without push of return address");

  take_clear_a: assert property (vector_valid && vector_addr == TLIC_VEC_HIGH |->
    !st.ctrl[TLIC_GHE_BIT])
    else $error("high enable not cleared on accept");

  low_gate_a: assert property (s_low_accept |->
    $past(st.ctrl[TLIC_GHE_BIT]) && $past(st.ctrl[TLIC_PLE_BIT]) && $past(st.priority_levels_enable))
    else $error("low vector taken without both enables");

  no_low_high_a: assert property (s_low_accept |->
    $past(st.svc) != TLIC_SVC_HIGH && $past(st.svc) != TLIC_SVC_HOL)
    else $error("low request taken during high service");

  flag_set_a: assert property (timer0_overflow || periph_event[0] |=>
    st.cflag[4] == $past(timer0_overflow) || st.cflag[4])
    else $error("event flag not set");

  periph_flag_a: assert property (periph_event[0] |=> st.pflag[0])
    else $error("peripheral flag not set");

  ext0_pri_a: assert property (reg_read && reg_addr == TLIC_OFS_CPRI |=>
    reg_rdata[0])
    else $error("external zero not reported high priority");

  ret_compat_a: assert property (return_from_interrupt && !st.priority_levels_enable && !vector_valid
    && !(fetch_strobe && st.armed) |=> st.ctrl[TLIC_GHE_BIT])
    else $error("return did not restore global enable");

  latency_a: assert property ($rose(st.sync2[0]) && st.ctrl[0] && st.ctrl[TLIC_GHE_BIT]
    && st.svc == TLIC_SVC_NONE && !st.priority_levels_enable && fetch_strobe ##1 fetch_strobe[*1]
    ##1 fetch_strobe |=> vector_valid)
    else $error("external event not vectored within latency");

endmodule // tlic_ctrl

// [tlic_core_model.sv]
`timescale 1ns/1ns
// ****
// Core fetch and program counter model
// ****
module tlic_core_model (
  // Clock, reset and bench controls
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] fetch_gap,
  input wire logic rfi_req,
  // Controller side
  input wire logic vector_valid,
  input wire logic [15:0] vector_addr,
  output logic fetch_strobe,
  output logic return_from_interrupt,
  output logic [15:0] return_address
);
  logic [3:0] gap_cnt;
  // Fetch pacing, return pulse and program counter
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_cnt <= 4'h0;
      fetch_strobe <= 1'b0;
      return_from_interrupt <= 1'b0;
      return_address <= 16'h0100;
    end
    else
    begin
      fetch_strobe <= (gap_cnt == 4'h0);
      gap_cnt <= (gap_cnt >= fetch_gap) ? 4'h0 : gap_cnt + 4'h1;
      return_from_interrupt <= rfi_req;
      if (vector_valid)
        return_address <= vector_addr;
      else if (fetch_strobe)
        return_address <= return_address + 16'h0001;
    end
  end
endmodule // tlic_core_model

// [tlic_ctrl_tb_top.sv]
`timescale 1ns/1ns
// ****
// Bench top
// ****
module tlic_ctrl_tb_top;
  import tlic_pkg::*;
  logic mclk, reset_n, reg_write, reg_read, port_change_pin, timer0_overflow, rfi_req;
  logic fetch_strobe, return_from_interrupt, vector_valid, push_valid;
  logic [2:0] reg_addr, ext_pin;
  logic [7:0] reg_wdata, reg_rdata, periph_event;
  logic [3:0] fetch_gap;
  logic [15:0] return_address, vector_addr, push_addr, ra_prev;
  int miscompares = 0;
  int cmp_count = 0;

  tlic_ctrl DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .port_change_pin(port_change_pin), .timer0_overflow(timer0_overflow),
    .periph_event(periph_event), .fetch_strobe(fetch_strobe),
    .return_from_interrupt(return_from_interrupt), .return_address(return_address),
    .vector_valid(vector_valid), .vector_addr(vector_addr), .push_valid(push_valid),
    .push_addr(push_addr));
  tlic_core_model u_core (.mclk(mclk), .reset_n(reset_n), .fetch_gap(fetch_gap),
    .rfi_req(rfi_req), .vector_valid(vector_valid), .vector_addr(vector_addr),
    .fetch_strobe(fetch_strobe), .return_from_interrupt(return_from_interrupt),
    .return_address(return_address));

  // Clock generator
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Return address seen before each edge
  always @(posedge mclk) ra_prev <= return_address;

  // ****
  // Helpers
  // ****
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Plain single-register write, never a memory-to-memory move
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic pulse_periph(input logic [7:0] v);
    @(posedge mclk);
    periph_event <= v;
    @(posedge mclk);
    periph_event <= 8'h00;
  endtask

  task automatic set_ext0(input logic v);
    @(posedge mclk);
    ext_pin[0] <= v;
  endtask

  task automatic rfi;
    @(posedge mclk);
    rfi_req <= 1'b1;
    @(posedge mclk);
    rfi_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic wait_vec(input logic [15:0] exp, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while (vector_valid !== 1'b1 && n < lim);
    if (vector_valid !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    else
    begin
      chk(vector_addr, exp);
      chk(push_addr, ra_prev);
      chk({15'h0000, push_valid}, 16'h0001);
    end
  endtask

  task automatic no_vec(input int lim);
    repeat (lim)
    begin
      @(posedge mclk);
      #1 chk({15'h0000, vector_valid}, 16'h0000);
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd(TLIC_OFS_CTRL, 8'h00);
    rd(TLIC_OFS_RSTCTL, 8'h00);
    rd(TLIC_OFS_CPRI, 8'h1f);
    rd(TLIC_OFS_PPRI, 8'hff);
    wr(TLIC_OFS_CTRL, 8'hff);
    rd(TLIC_OFS_CTRL, 8'hdf);
    wr(TLIC_OFS_CTRL, 8'h00);
  endtask

  task automatic t_flags;
    @(posedge mclk);
    ext_pin <= 3'h7;
    port_change_pin <= 1'b1;
    timer0_overflow <= 1'b1;
    periph_event <= 8'hff;
    @(posedge mclk);
    timer0_overflow <= 1'b0;
    periph_event <= 8'h00;
    repeat (4) @(posedge mclk);
    rd(TLIC_OFS_CFLAG, 8'h1f);
    rd(TLIC_OFS_PFLAG, 8'hff);
    wr(TLIC_OFS_STATUS, 8'hff);
    rd(TLIC_OFS_STATUS, 8'h01);
    @(posedge mclk);
    ext_pin <= 3'h0;
    wr(TLIC_OFS_CFLAG, 8'h00);
    wr(TLIC_OFS_PFLAG, 8'h00);
    rd(TLIC_OFS_CFLAG, 8'h00);
  endtask

  task automatic t_compat_ext0(input logic [3:0] gap);
    @(posedge mclk);
    fetch_gap <= gap;
    wr(TLIC_OFS_CTRL, 8'h81);
    set_ext0(1'b1);
    wait_vec(TLIC_VEC_HIGH, 4 * (gap + 1) + 4);
    rd(TLIC_OFS_CTRL, 8'h01);
    rd(TLIC_OFS_STATUS, 8'h04);
    set_ext0(1'b0);
    wr(TLIC_OFS_CFLAG, 8'h00);
    rfi();
    rd(TLIC_OFS_CTRL, 8'h81);
    rd(TLIC_OFS_STATUS, 8'h01);
    wr(TLIC_OFS_CTRL, 8'h00);
  endtask

  task automatic t_compat_periph;
    wr(TLIC_OFS_PEN, 8'h01);
    wr(TLIC_OFS_PPRI, 8'hfe);
    pulse_periph(8'h01);
    wr(TLIC_OFS_CTRL, 8'h40);
    no_vec(20);
    wr(TLIC_OFS_CTRL, 8'h80);
    no_vec(20);
    rd(TLIC_OFS_PFLAG, 8'h01);
    wr(TLIC_OFS_CTRL, 8'hc0);
    wait_vec(TLIC_VEC_HIGH, 40);
    rd(TLIC_OFS_CTRL, 8'h40);
    wr(TLIC_OFS_PFLAG, 8'h00);
    rfi();
    rd(TLIC_OFS_CTRL, 8'hc0);
    wr(TLIC_OFS_CTRL, 8'h00);
  endtask

  task automatic t_prio;
    wr(TLIC_OFS_RSTCTL, 8'h80);
    rd(TLIC_OFS_RSTCTL, 8'h80);
    wr(TLIC_OFS_CPRI, 8'h00);
    rd(TLIC_OFS_CPRI, 8'h01);
    pulse_periph(8'h01);
    wr(TLIC_OFS_CTRL, 8'h80);
    no_vec(20);
    wr(TLIC_OFS_CTRL, 8'h40);
    no_vec(20);
    wr(TLIC_OFS_CTRL, 8'hc1);
    wait_vec(TLIC_VEC_LOW, 40);
    rd(TLIC_OFS_CTRL, 8'h81);
    set_ext0(1'b1);
    wait_vec(TLIC_VEC_HIGH, 40);
    rd(TLIC_OFS_STATUS, 8'h08);
    rd(TLIC_OFS_CTRL, 8'h01);
    set_ext0(1'b0);
    wr(TLIC_OFS_CFLAG, 8'h00);
    rfi();
    rd(TLIC_OFS_STATUS, 8'h02);
    rd(TLIC_OFS_CTRL, 8'h81);
    wr(TLIC_OFS_PFLAG, 8'h00);
    rfi();
    rd(TLIC_OFS_CTRL, 8'hc1);
    set_ext0(1'b1);
    wait_vec(TLIC_VEC_HIGH, 40);
    set_ext0(1'b0);
    wr(TLIC_OFS_CFLAG, 8'h00);
    pulse_periph(8'h01);
    wr(TLIC_OFS_CTRL, 8'hc1);
    no_vec(20);
    rd(TLIC_OFS_STATUS, 8'h04);
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    ext_pin = 3'h0;
    port_change_pin = 1'b0;
    timer0_overflow = 1'b0;
    periph_event = 8'h00;
    rfi_req = 1'b0;
    fetch_gap = 4'h3;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_flags();
    t_compat_ext0(4'h0);
    t_compat_ext0(4'h1);
    t_compat_ext0(4'h3);
    t_compat_periph();
    t_prio();
    conclude();
  end
endmodule // tlic_ctrl_tb_top
